//--- logic/mac_stage.sv
// Post-multiply pipeline, adder, accumulator, summation and output stage.
// Functional notes
// - Optional product register pipelines add paths; in wide mode it pipelines the multiply.
// - Output register selectable in every mode, always used for accumulation.
// - Adders only take multiplier products; no outside adder operands exist.
// - Add/subtract select high adds, low subtracts.
// - Two add/subtract selects; narrow mode: one for upper pair, one for lower.
// - Add/subtract select delayed by zero, one or two stages.
// - Sign controls shared with multipliers, delayed up to two stages, same control set.
// - Accumulator load replaces the sum with the current product on the edge.
// - Overflow flag is registered and not sticky; holding it is the user's job.
// - Summation: two four-product sums narrow, one four-product sum at 18 bits.
// - Output multiplexer picks products, adder results or summation by mode.
// - Output registers use one of four enable and clear sets, any mode.
// - Exactly one arithmetic mode per block at a time.
// - Simple mode passes four 18-bit or eight 9-bit products out.
// - Wide mode combines four partial products by adding and shifting.
// - Accumulate mode: two accumulators fed by the second and fourth multipliers.
// - Accumulator is 52 bits: 36-bit product plus 16 headroom bits.
// - Load and overflow only in accumulate mode; subtraction reports underflow.
// - Two-multiplier adder: two 18-bit pair results or four 9-bit ones.
// - Complex product: one subtractor real, one adder imaginary per pair.
// - Four-multiplier adder sums two first-level results; equal widths required.
// - Four-product sum forms a four-tap filter; longer filters cascade outside.
// - Sign control one means signed; result signed if either operand signed.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mac_consts.svh"
module mac_stage (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire mac_pkg::mac_prod_s prod_i,
   input wire mac_pkg::mac_ctl_s ctl_i,
   output logic [143:0] result_o,
   output logic [1:0] overflow_o
);

   // Extends an 18- or 36-bit product to a lane, signed when asked.
   function automatic logic [71:0] sx(input logic [35:0] v, input logic wide, input logic sg);
      logic [71:0] r;
      r = '0;
      if (wide) begin
         r = {{36{sg & v[35]}}, v};
      end else begin
         r = {{54{sg & v[17]}}, v[17:0]};
      end
      return r;
   endfunction : sx

   // Adds when the select is high and subtracts when it is low.
   function automatic logic [71:0] addsub(input logic [71:0] a, input logic [71:0] b,
                                          input logic add);
      return add ? a + b : a - b;
   endfunction : addsub

   // Picks the current, once- or twice-registered copy of a control.
   function automatic logic pick(input logic [1:0] lat, input logic c0, input logic c1,
                                 input logic c2);
      return (lat == 2'd0) ? c0 : ((lat == 2'd1) ? c1 : c2);
   endfunction : pick

   mac_pkg::mac_state_s q;
   mac_pkg::mac_state_s d;
   logic [3:0][35:0] pw;
   logic [7:0][35:0] nq;
   logic [3:0][71:0] fl;
   logic [1:0][71:0] acc_sum;
   logic [1:0][71:0] acc_in;
   logic [143:0] res_c;
   logic sg;
   logic [1:0] add_c;
   logic [1:0] load_c;
   logic pena;
   logic pclr;
   logic oena;
   logic oclr;
   logic oreg;
   logic nar;
   mac_pkg::mac_mode_e mode;

   // Control set selection and the delayed sign, select and load controls.
   always_comb begin
      mode = q.cfg.mode;
      nar = q.cfg.narrow;
      pena = ctl_i.ena[q.cfg.pipe_set];
      pclr = ctl_i.aclr[q.cfg.pipe_set];
      oena = ctl_i.ena[q.cfg.out_set];
      oclr = ctl_i.aclr[q.cfg.out_set];
      oreg = q.cfg.out_en | (mode == mac_pkg::MAC_ACCUM);
      sg = pick(q.cfg.lat_sign, ctl_i.sign_a | ctl_i.sign_b, q.dly1.sign, q.dly2.sign);
      for (int i = 0; i < 2; i++) begin
         add_c[i] = pick(q.cfg.lat_add, ctl_i.addnsub[i], q.dly1.addnsub[i],
                         q.dly2.addnsub[i]);
         load_c[i] = pick(q.cfg.lat_load, ctl_i.sload[i], q.dly1.sload[i],
                          q.dly2.sload[i]);
      end
   end

   // Product source: registered copy when pipelined, cleared at once by its clear.
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (!q.cfg.pipe_en) begin
            pw[k] = prod_i.word[k];
         end else if (pclr) begin
            pw[k] = '0;
         end else begin
            pw[k] = q.prod.word[k];
         end
         nq[2 * k] = {18'h0_0000, pw[k][17:0]};
         nq[2 * k + 1] = {18'h0_0000, pw[k][35:18]};
      end
   end

   // First-level adders, summation, accumulators and the output multiplexer.
   always_comb begin
      res_c = '0;
      fl = '0;
      acc_sum = '0;
      acc_in = '0;
      // Only products reach the adders; the stage has no other operand inputs.
      if (nar) begin
         for (int j = 0; j < 4; j++) begin
            fl[j] = addsub(sx(nq[2 * j], 1'b0, sg), sx(nq[2 * j + 1], 1'b0, sg),
                           add_c[j / 2]);
         end
      end else begin
         for (int j = 0; j < 2; j++) begin
            fl[j] = addsub(sx(pw[2 * j], 1'b1, sg), sx(pw[2 * j + 1], 1'b1, sg),
                           add_c[j]);
         end
      end
      for (int a = 0; a < 2; a++) begin
         acc_in[a] = sx(pw[2 * a + 1], ~nar, sg);
         acc_sum[a] = addsub(sx(q.acc[a][51:16], 1'b1, sg) << 16 | {56'h0, q.acc[a][15:0]},
                             acc_in[a], add_c[a]);
      end
      case (mode)
         mac_pkg::MAC_SIMPLE: begin
            res_c = pw;
         end
         mac_pkg::MAC_ACCUM: begin
            res_c = {20'h0_0000, q.acc[1], 20'h0_0000, q.acc[0]};
         end
         mac_pkg::MAC_ADD2: begin
            if (nar) begin
               res_c = {fl[3][35:0], fl[2][35:0], fl[1][35:0], fl[0][35:0]};
            end else begin
               res_c = {fl[1], fl[0]};
            end
         end
         mac_pkg::MAC_ADD4: begin
            if (nar) begin
               res_c = {fl[2] + fl[3], fl[0] + fl[1]};
            end else begin
               res_c = {72'h0, fl[0] + fl[1]};
            end
         end
         mac_pkg::MAC_WIDE: begin
            res_c = {72'h0, sx(pw[0], 1'b1, 1'b0) + ((sx(pw[1], 1'b1, sg)
                     + sx(pw[2], 1'b1, sg)) << 18) + (sx(pw[3], 1'b1, sg) << 36)};
         end
         default: begin
            res_c = '0;
         end
      endcase
   end

   // Next state: bus slave, delay stages, product register, accumulators, outputs.
   always_comb begin
      d = q;
      d.ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !q.ack) begin
         d.ack = 1'b1;
         d.rdat = '0;
         if (wb_adr_i == `MAC_ADR_CFG) begin
            d.rdat = {16'h0000, q.cfg};
            if (wb_we_i && wb_sel_i[0]) begin
               d.cfg[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
               d.cfg[15:8] = wb_dat_i[15:8];
            end
         end else if (wb_adr_i == `MAC_ADR_STAT) begin
            d.rdat = {29'h000_0000, oreg, q.ovf};
         end
      end
      if (pclr) begin
         d.dly1 = '0;
         d.dly2 = '0;
         d.prod = '0;
      end else if (pena) begin
         d.dly1 = {ctl_i.sign_a | ctl_i.sign_b, ctl_i.addnsub, ctl_i.sload};
         d.dly2 = q.dly1;
         d.prod = prod_i;
      end
      if (oclr || mode != mac_pkg::MAC_ACCUM) begin
         d.acc = '0;
         d.ovf = '0;
      end else if (oena) begin
         for (int a = 0; a < 2; a++) begin
            if (load_c[a]) begin
               d.acc[a] = acc_in[a][51:0];
               d.ovf[a] = 1'b0;
            end else begin
               d.acc[a] = acc_sum[a][51:0];
               d.ovf[a] = sg ? (acc_sum[a][52] ^ acc_sum[a][51]) : acc_sum[a][52];
            end
         end
      end
      if (oclr) begin
         d.res = '0;
      end else if (oena) begin
         d.res = res_c;
      end
   end

   // Single register process for the whole stage.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.cfg <= mac_pkg::mac_cfg_s'(16'(`MAC_CFG_RST));
      end else begin
         q <= d;
      end
   end

   // Outputs: clears zero a registered result at once, the overflow flag at the next edge; the accumulator result is always registered.
   always_comb begin
      wb_ack_o = q.ack;
      wb_dat_o = q.rdat;
      overflow_o = q.ovf;
      if (oreg && oclr) begin
         result_o = '0;
      end else if (mode == mac_pkg::MAC_ACCUM) begin
         result_o = {20'h0_0000, q.acc[1], 20'h0_0000, q.acc[0]};
      end else if (oreg) begin
         result_o = q.res;
      end else begin
         result_o = res_c;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic comb_path;
   assign comb_path = !q.cfg.pipe_en && !oreg && q.cfg.lat_add == 2'd0;

   AST_ADD_SELECT: assert property (comb_path && mode == mac_pkg::MAC_ADD2 && !nar
      |-> result_o[71:0] == (ctl_i.addnsub[0] ? sx(prod_i.word[0], 1'b1, sg)
          + sx(prod_i.word[1], 1'b1, sg) : sx(prod_i.word[0], 1'b1, sg)
          - sx(prod_i.word[1], 1'b1, sg)))
      else $error("first-level adder ignores its select");
   AST_SIMPLE_PASS: assert property (comb_path && mode == mac_pkg::MAC_SIMPLE
      |-> result_o == prod_i.word)
      else $error("simple mode does not pass the products");
   AST_NO_OVF_OUTSIDE: assert property (mode != mac_pkg::MAC_ACCUM && $stable(mode)
      |=> overflow_o == 2'b00)
      else $error("overflow outside accumulate mode");
   AST_SLOAD: assert property (mode == mac_pkg::MAC_ACCUM && q.cfg.lat_load == 2'd0
      && ctl_i.sload[0] && oena && !oclr && $stable(q.cfg)
      |=> q.acc[0] == $past(acc_in[0][51:0]))
      else $error("load does not replace the accumulator");
   AST_OUT_CLEAR: assert property (oreg && oclr |-> result_o == '0)
      else $error("clear does not zero the output");
   AST_OUT_HOLD: assert property (oreg && !oena && !oclr && $stable(q.cfg)
      ##1 !oclr && $stable(q.cfg) |-> result_o == $past(result_o))
      else $error("output moves with enable low");
   AST_ADD_LAT2: assert property (q.cfg.lat_add == 2'd2 && !pclr && pena
      ##1 !pclr && pena ##1 $stable(q.cfg) |-> add_c[1] == $past(ctl_i.addnsub[1], 2))
      else $error("select latency two broken");
   AST_ACC_REG: assert property (mode == mac_pkg::MAC_ACCUM && !oclr
      |-> result_o[51:0] == q.acc[0])
      else $error("accumulator output not registered");
   AST_OVF_CLEARS: assert property (mode == mac_pkg::MAC_ACCUM && overflow_o[0] && oena
      && !oclr && load_c[0] |=> !overflow_o[0])
      else $error("overflow flag is sticky");

   COV_ACC_OVF: cover property (mode == mac_pkg::MAC_ACCUM ##1 overflow_o[0]);
   COV_ADD4_NARROW: cover property (mode == mac_pkg::MAC_ADD4 && nar && oreg);
   COV_WIDE_PIPE: cover property (mode == mac_pkg::MAC_WIDE && q.cfg.pipe_en);
endmodule : mac_stage

//--- logic/mac_consts.svh
// Constants for the post-multiply adder and output stage.
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH
`define MAC_ADR_CFG 8'h00
`define MAC_ADR_STAT 8'h04
`define MAC_CFG_RST 32'h0000_0000
`define MAC_CFG_MODE_LSB 0
`define MAC_CFG_NARROW 3
`define MAC_CFG_PIPE_EN 4
`define MAC_CFG_OUT_EN 5
`define MAC_CFG_PSET_LSB 6
`define MAC_CFG_OSET_LSB 8
`define MAC_CFG_LADD_LSB 10
`define MAC_CFG_LSIGN_LSB 12
`define MAC_CFG_LLOAD_LSB 14
`define MAC_CFG_W 16
`define MAC_ACC_W 52
`define MAC_HALF_W 18
`define MAC_WORD_W 36
`define MAC_LANE_W 72
`endif

//--- logic/mac_pkg.sv
// Types shared by the post-multiply adder and output stage.
package mac_pkg;
   typedef enum logic [2:0] {
      MAC_SIMPLE,
      MAC_ACCUM,
      MAC_ADD2,
      MAC_ADD4,
      MAC_WIDE
   } mac_mode_e;
   typedef struct packed {
      logic [1:0] lat_load;
      logic [1:0] lat_sign;
      logic [1:0] lat_add;
      logic [1:0] out_set;
      logic [1:0] pipe_set;
      logic out_en;
      logic pipe_en;
      logic narrow;
      mac_mode_e mode;
   } mac_cfg_s;
   typedef struct packed {
      logic [3:0][35:0] word;
   } mac_prod_s;
   typedef struct packed {
      logic sign_a;
      logic sign_b;
      logic [1:0] addnsub;
      logic [1:0] sload;
      logic [3:0] ena;
      logic [3:0] aclr;
   } mac_ctl_s;
   typedef struct packed {
      logic sign;
      logic [1:0] addnsub;
      logic [1:0] sload;
   } mac_dly_s;
   typedef struct packed {
      mac_cfg_s cfg;
      logic ack;
      logic [31:0] rdat;
      mac_prod_s prod;
      mac_dly_s dly1;
      mac_dly_s dly2;
      logic [1:0][51:0] acc;
      logic [1:0] ovf;
      logic [143:0] res;
   } mac_state_s;
endpackage : mac_pkg

//--- dv/mac_fab.sv
// Fabric model that multiplies operand pairs and feeds the stage.
`timescale 1ns/1ps
module mac_fab (
   input wire logic [3:0][17:0] a_i,
   input wire logic [3:0][17:0] b_i,
   input wire logic sign_a_i,
   input wire logic sign_b_i,
   input wire logic narrow_i,
   output mac_pkg::mac_prod_s prod_o
);
   // Each word is one pair product, or two 9-bit products in narrow mode.
   always_comb begin
      logic [17:0] lo;
      logic [17:0] hi;
      lo = '0;
      hi = '0;
      for (int k = 0; k < 4; k++) begin
         if (narrow_i) begin
            lo = {{9{sign_a_i & a_i[k][8]}}, a_i[k][8:0]} *
               {{9{sign_b_i & b_i[k][8]}}, b_i[k][8:0]};
            hi = {{9{sign_a_i & a_i[k][17]}}, a_i[k][17:9]} *
               {{9{sign_b_i & b_i[k][17]}}, b_i[k][17:9]};
            prod_o.word[k] = {hi, lo};
         end else begin
            prod_o.word[k] = {{18{sign_a_i & a_i[k][17]}}, a_i[k]} *
               {{18{sign_b_i & b_i[k][17]}}, b_i[k]};
         end
      end
   end
endmodule : mac_fab

//--- dv/tb_top.sv
// Self-checking bench for the post-multiply stage.
`timescale 1ns/1ps
`include "mac_consts.svh"
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0][17:0] op_a = '0;
   logic [3:0][17:0] op_b = '0;
   logic nar = 1'b0;
   mac_pkg::mac_prod_s prod;
   mac_pkg::mac_ctl_s ctl = '0;
   logic [143:0] result_o;
   logic [1:0] overflow_o;
   logic [145:0] exp_q[$];
   logic [145:0] msk_q[$];
   int n_fail = 0;
   int comparisons = 0;
   event look;

   // Clock of 40 ns.
   always #20 clk_i = ~clk_i;

   mac_fab u_mac_fab (.a_i(op_a), .b_i(op_b), .sign_a_i(ctl.sign_a), .sign_b_i(ctl.sign_b),
      .narrow_i(nar), .prod_o(prod));
   mac_stage u_mac_stage (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prod_i(prod),
      .ctl_i(ctl), .result_o(result_o), .overflow_o(overflow_o));

   task automatic print_verdict;
      if (n_fail == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [145:0] s, input logic [145:0] w, input logic [145:0] m);
      comparisons++;
      if ((s & m) !== (w & m)) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, s & m, w & m);
      end
   endtask : check

   task automatic note(input logic [145:0] e, input logic [145:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      ->look;
   endtask : note

   // Compares overflow and result with the oldest expectation.
   always @(look) begin
      check({overflow_o, result_o}, exp_q.pop_front(), msk_q.pop_front());
   end

   // One classic bus cycle, entered right after a rising edge.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
      int i;
      logic got;
      got = 1'b0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
      if (!got) begin
         n_fail++;
         $display("CHECK FAILED %0t no bus answer", $time);
         print_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   function automatic logic [71:0] px(input int k);
      logic [71:0] a;
      logic [71:0] b;
      a = {{54{ctl.sign_a & op_a[k][17]}}, op_a[k]};
      b = {{54{ctl.sign_b & op_b[k][17]}}, op_b[k]};
      return a * b;
   endfunction : px

   // One 9-bit product: half h of operand pair k.
   function automatic logic [71:0] pn(input int k, input int h);
      logic [71:0] a;
      logic [71:0] b;
      a = {{63{ctl.sign_a & op_a[k][9 * h + 8]}}, op_a[k][9 * h +: 9]};
      b = {{63{ctl.sign_b & op_b[k][9 * h + 8]}}, op_b[k][9 * h +: 9]};
      return a * b;
   endfunction : pn

   task automatic rnd;
      op_a <= 72'({$urandom, $urandom, $urandom}) | {4{18'h0_0001}};
      op_b <= 72'({$urandom, $urandom, $urandom}) | {4{18'h0_0001}};
   endtask : rnd

   // Main sequence: registers, combinational modes, pipelining, accumulation, clear.
   initial begin
      logic [31:0] rd;
      logic [3:0][71:0] p;
      logic [3:0][71:0] r;
      logic [5:0][1:0] hs;
      logic [71:0] l0;
      logic [71:0] l1;
      logic [35:0] aw;
      logic [35:0] bw;
      logic [51:0] q0;
      logic [51:0] q1;
      logic [1:0] ov;
      logic [145:0] e;
      logic [145:0] mw;
      logic [145:0] ma;
      int k;
      k = $urandom(32'h0000_05f4);
      mw = {2'b11, {72{1'b0}}, {72{1'b1}}};
      ma = {2'b11, 20'h0_0000, {52{1'b1}}, 20'h0_0000, {52{1'b1}}};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, `MAC_ADR_CFG, 32'h0000_0000, rd);
      check(146'(rd), 146'(`MAC_CFG_RST), '1);
      wb(1'b0, 8'h08, 32'h0000_0000, rd);
      check(146'(rd), '0, '1);
      wb(1'b1, `MAC_ADR_CFG, 32'h0000_0020, rd);
      wb(1'b0, `MAC_ADR_STAT, 32'h0000_0000, rd);
      check(146'(rd), 146'(32'h0000_0004), 146'(32'h0000_0004));
      // Modes simple, wide, add2 and add4: each select value once, signs set from the same bits, wide unsigned only.
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `MAC_ADR_CFG, (m == 1) ? 32'h0000_0004 : 32'(m), rd);
         for (k = 0; k < 4; k++) begin
            aw = 36'({$urandom, $urandom});
            bw = 36'({$urandom, $urandom});
            if (m == 1) begin
               op_a <= {aw[35:18], aw[35:18], aw[17:0], aw[17:0]};
               op_b <= {bw[35:18], bw[17:0], bw[35:18], bw[17:0]};
            end else begin
               rnd();
            end
            ctl.addnsub <= k[1:0];
            ctl.sign_a <= (m != 1) & k[0];
            ctl.sign_b <= (m != 1) & k[1];
            @(negedge clk_i);
            for (int i = 0; i < 4; i++) p[i] = px(i);
            l0 = ctl.addnsub[0] ? p[0] + p[1] : p[0] - p[1];
            l1 = ctl.addnsub[1] ? p[2] + p[3] : p[2] - p[3];
            case (m)
               0: note({2'b00, p[3][35:0], p[2][35:0], p[1][35:0], p[0][35:0]}, '1);
               1: note(146'(72'(aw) * 72'(bw)), mw);
               2: note({2'b00, l1, l0}, '1);
               default: note(146'(l0 + l1), mw);
            endcase
            @(posedge clk_i);
         end
      end
      // Narrow 9-bit lanes: four pair results, then two four-product sums.
      nar <= 1'b1;
      for (int m = 2; m < 4; m++) begin
         wb(1'b1, `MAC_ADR_CFG, 32'h0000_0008 | 32'(m), rd);
         for (k = 0; k < 4; k++) begin
            rnd();
            ctl.addnsub <= k[1:0];
            ctl.sign_a <= k[0];
            ctl.sign_b <= k[1];
            @(negedge clk_i);
            for (int i = 0; i < 4; i++) begin
               r[i] = ctl.addnsub[i / 2] ? pn(i, 0) + pn(i, 1) : pn(i, 0) - pn(i, 1);
            end
            if (m == 2) begin
               note({2'b00, r[3][35:0], r[2][35:0], r[1][35:0], r[0][35:0]}, '1);
            end else begin
               note({2'b00, r[2] + r[3], r[0] + r[1]}, '1);
            end
            @(posedge clk_i);
         end
      end
      nar <= 1'b0;
      // Select latency two on control set 1: each result uses the select of two edges before.
      wb(1'b1, `MAC_ADR_CFG, 32'h0000_0842, rd);
      ctl.ena <= 4'h2;
      ctl.sign_a <= 1'b1;
      ctl.sign_b <= 1'b0;
      for (k = 0; k < 6; k++) begin
         hs[k] = 2'($urandom);
         ctl.addnsub <= hs[k];
         rnd();
         @(negedge clk_i);
         for (int i = 0; i < 4; i++) p[i] = px(i);
         if (k > 1) begin
            l0 = hs[k - 2][0] ? p[0] + p[1] : p[0] - p[1];
            l1 = hs[k - 2][1] ? p[2] + p[3] : p[2] - p[3];
            note({2'b00, l1, l0}, '1);
         end
         @(posedge clk_i);
      end
      // Product pipeline, then output register on set 2: one edge of latency, hold on low enable.
      for (int c = 0; c < 2; c++) begin
         wb(1'b1, `MAC_ADR_CFG, c ? 32'h0000_0220 : 32'h0000_0010, rd);
         for (k = 0; k < 3; k++) begin
            ctl.ena <= 4'(k != 1) << (2 * c);
            rnd();
            @(posedge clk_i);
            @(negedge clk_i);
            for (int i = 0; i < 4; i++) p[i] = px(i);
            if (k != 1) e = {2'b00, p[3][35:0], p[2][35:0], p[1][35:0], p[0][35:0]};
            note(e, '1);
            @(posedge clk_i);
         end
      end
      // Accumulate: load, add, subtract to underflow, reload; one enabled edge per step.
      wb(1'b1, `MAC_ADR_CFG, 32'h0000_0001, rd);
      rnd();
      ctl.sign_a <= 1'b0;
      ctl.sign_b <= 1'b0;
      q0 = '0;
      q1 = '0;
      for (k = 0; k < 6; k++) begin
         ctl.sload <= (k == 0 || k == 5) ? 2'b11 : 2'b00;
         ctl.addnsub <= (k < 2) ? 2'b11 : 2'b00;
         ctl.ena <= 4'h1;
         @(posedge clk_i);
         ctl.ena <= 4'h0;
         @(negedge clk_i);
         p[1] = px(1);
         p[3] = px(3);
         q0 = ctl.sload[0] ? p[1][51:0] : (ctl.addnsub[0] ? q0 + p[1][51:0] : q0 - p[1][51:0]);
         q1 = ctl.sload[1] ? p[3][51:0] : (ctl.addnsub[1] ? q1 + p[3][51:0] : q1 - p[3][51:0]);
         ov = (k == 4) ? 2'b11 : 2'b00;
         note({ov, 20'h0_0000, q1, 20'h0_0000, q0}, ma);
         @(posedge clk_i);
      end
      ctl.aclr <= 4'h1;
      @(negedge clk_i);
      note('0, ma);
      @(posedge clk_i);
      ctl.aclr <= 4'h0;
      @(posedge clk_i);
      print_verdict();
   end
endmodule : tb_top
